// ### verilog/applied_gain_readback_dynamics.sv
/*
 Gain dynamics of an audio level controller: gain limits, gain readback,
 peak-driven attack and decay, clip guard look-ahead, fast release and
 expected level seeding. Samples pass through a FIFO to the output.
 Assumes a register port driven by logic on the same clock and a sample
 source and sink that use valid and ready.
*/
// Notes on behaviour
// - Minimum gain code decodes 0, -12, -18, -24, -36 dB; reserved codes clamp.
// - Maximum gain code decodes 12, 18, 24, 36 dB; gain never exceeds it.
// - Applied gain reads back as 16-bit unsigned, 7 integer bits.
// - Readback value divided by 512 is the linear gain.
// - Attack and decay move on tracked peak amplitude; the clip guard acts on the instantaneous sample.
// - Attack lowers gain on high level; decay raises it on low level.
// - Attack code picks rate 181us to 185.6ms per 6dB, doubling per code.
// - Decay code picks rate 186ms to 47.56s per 6dB, doubling per code.
// - Clip guard looks ahead and speeds attack when output would clip.
// - Clip guard adds look-ahead delay to the sample path.
// - Fast release uses its own rate while crest factor exceeds threshold.
// - Crest threshold code decodes 12, 18, 24, 30 dB.
// - Fast release code decodes 0.725, 1.45, 5.8 ms per 6dB.
// - Initial level code seeds expected level, 0 dB down in 3.75 dB steps.
// - Seeding touches only the level estimate, never the applied gain.
// - Compression regions use minimum gain; gate region uses gate minimum.
`timescale 1ns/1ps
module applied_gain_readback_dynamics #(
    parameter int ATK_BASE_CYC = dyn_pkg::ATK_BASE_CYC_DEF,
    parameter int DCY_BASE_CYC = dyn_pkg::DCY_BASE_CYC_DEF
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [23:0] in_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [23:0] out_data
);
    import dyn_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [15:0] feat_ff;
    logic [15:0] limit_ff;
    logic [15:0] time_ff;
    logic [15:0] frel_ff;
    logic [15:0] init_ff;
    logic [15:0] gain_ff;
    logic [15:0] rdata_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            feat_ff  <= FEAT_RST;
            limit_ff <= LIMIT_RST;
            time_ff  <= TIME_RST;
            frel_ff  <= FREL_RST;
            init_ff  <= INIT_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                FEAT_ADDR:  feat_ff  <= reg_wdata & FEAT_MASK;
                LIMIT_ADDR: limit_ff <= reg_wdata & LIMIT_MASK;
                TIME_ADDR:  time_ff  <= reg_wdata & TIME_MASK;
                FREL_ADDR:  frel_ff  <= reg_wdata & FREL_MASK;
                INIT_ADDR:  init_ff  <= reg_wdata & INIT_MASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else begin
            case (reg_addr)
                FEAT_ADDR:  rdata_ff <= feat_ff;
                LIMIT_ADDR: rdata_ff <= limit_ff;
                TIME_ADDR:  rdata_ff <= time_ff;
                FREL_ADDR:  rdata_ff <= frel_ff;
                INIT_ADDR:  rdata_ff <= init_ff;
                GAIN_ADDR:  rdata_ff <= gain_ff;
                default:    rdata_ff <= '0;
            endcase
        end
    end
    assign reg_rdata = rdata_ff;

    // ****************************************************************
    // Field decode
    // ****************************************************************
    logic        ena;
    logic        gate_ena;
    logic        frel_ena;
    logic        guard;
    logic [2:0]  min_c;
    logic [3:0]  gmin_c;
    logic [3:0]  atk_c;
    logic [3:0]  dcy_c;
    logic [1:0]  rate_c;
    logic [4:0]  init_c;
    logic [15:0] min_lim;
    logic [15:0] hi_lim;
    logic [15:0] lo_raw;
    logic [15:0] eff_lo;
    logic [23:0] atk_per;
    logic [23:0] dcy_per;
    logic [23:0] fr_per;
    logic [23:0] seed;
    logic        gate_region;

    assign ena      = feat_ff[ENA_BIT];
    assign gate_ena = feat_ff[GATE_BIT];
    assign frel_ena = feat_ff[FREL_BIT];
    assign guard    = feat_ff[GUARD_BIT];
    assign init_c   = init_ff[INIT_LSB +: 5];

    // Minimum gain decode with reserved clamp.
    assign min_c   = (limit_ff[MIN_LSB +: 3] > MIN_CODE_MAX) ? MIN_CODE_MAX : limit_ff[MIN_LSB +: 3];
    assign min_lim = MIN_TBL[min_c];
    assign hi_lim  = MAX_TBL[limit_ff[MAX_LSB +: 2]];
    assign gmin_c  = (limit_ff[GMIN_LSB +: 4] > GMIN_CODE_MAX) ? GMIN_CODE_MAX : limit_ff[GMIN_LSB +: 4];
    // Gate region uses its own floor.
    assign lo_raw  = gate_region ? GMIN_TBL[gmin_c] : min_lim;
    // The ceiling wins when a floor lies above it.
    assign eff_lo  = (lo_raw > hi_lim) ? hi_lim : lo_raw;

    assign atk_c   = (time_ff[ATK_LSB +: 4] < ATK_CODE_MIN) ? ATK_CODE_MIN :
                     (time_ff[ATK_LSB +: 4] > ATK_CODE_MAX) ? ATK_CODE_MAX : time_ff[ATK_LSB +: 4];
    assign atk_per = 24'(ATK_BASE_CYC) << (atk_c - ATK_CODE_MIN);
    assign dcy_c   = (time_ff[DCY_LSB +: 4] > DCY_CODE_MAX) ? DCY_CODE_MAX : time_ff[DCY_LSB +: 4];
    assign dcy_per = 24'(DCY_BASE_CYC) << dcy_c;
    assign rate_c  = (frel_ff[RATE_LSB +: 2] > FREL_CODE_MAX) ? FREL_CODE_MAX : frel_ff[RATE_LSB +: 2];
    assign fr_per  = FR_CYC[rate_c];
    // Seed is a mantissa step shifted by whole 30 dB spans.
    assign seed    = SEED_TBL[init_c[2:0]] >> (4'(init_c[4:3]) * 4'(SEED_OCT_SHIFT));

    // ****************************************************************
    // Sample path
    // ****************************************************************
    logic        accept;
    logic        proc_valid_ff;
    logic [23:0] proc_data_ff;
    logic        fifo_ready;
    logic [23:0] dly_ff [LOOKAHEAD];
    logic [23:0] path_sample;
    logic [40:0] out_prod;
    logic [23:0] out_sat;
    logic [23:0] abs_in;

    assign in_ready = !proc_valid_ff || fifo_ready;
    assign accept   = in_valid && in_ready;
    assign abs_in   = in_data[23] ? 24'(-in_data) : in_data;

    // Clip guard takes the sample from the end of the delay line.
    assign path_sample = guard ? dly_ff[LOOKAHEAD-1] : in_data;
    assign out_prod    = $signed(path_sample) * $signed({1'b0, gain_ff});

    always_comb begin
        out_sat = out_prod[GAIN_FRAC +: 24];
        if (out_prod[40:32] != {9{out_prod[32]}}) begin
            out_sat = out_prod[40] ? ~FULL_SCALE : FULL_SCALE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LOOKAHEAD; i++) begin
                dly_ff[i] <= '0;
            end
        end else if (accept) begin
            dly_ff[0] <= in_data;
            for (int i = 1; i < LOOKAHEAD; i++) begin
                dly_ff[i] <= dly_ff[i-1];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            proc_valid_ff <= 1'b0;
            proc_data_ff  <= '0;
        end else if (accept) begin
            proc_valid_ff <= 1'b1;
            proc_data_ff  <= out_sat;
        end else if (fifo_ready) begin
            proc_valid_ff <= 1'b0;
        end
    end

    sample_fifo #(
        .WIDTH (24),
        .DEPTH (8)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (proc_valid_ff),
        .in_ready  (fifo_ready),
        .in_data   (proc_data_ff),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ****************************************************************
    // Level tracking
    // ****************************************************************
    logic        ena_d_ff;
    logic [23:0] peak_ff;
    logic [23:0] avg_ff;
    logic [23:0] peak_dec;
    logic [24:0] avg_diff;
    logic [31:0] crest_ref;
    logic        crest_hi;

    assign peak_dec  = peak_ff - (peak_ff >> PEAK_SHIFT);
    assign avg_diff  = {1'b0, abs_in} - {1'b0, avg_ff};
    // Threshold is a shift of 2 to 5 octaves of the mean level.
    assign crest_ref = {8'h00, avg_ff} << (3'(frel_ff[THR_LSB +: 2]) + 3'(THR_SHIFT0));
    assign crest_hi  = {8'h00, peak_ff} > crest_ref;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ena_d_ff <= 1'b0;
            peak_ff  <= '0;
            avg_ff   <= '0;
        end else begin
            ena_d_ff <= ena;
            if (ena && !ena_d_ff) begin
                peak_ff <= seed;
                avg_ff  <= seed;
            end else if (accept) begin
                peak_ff <= (abs_in > peak_dec) ? abs_in : peak_dec;
                avg_ff  <= avg_ff + 24'($signed(avg_diff) >>> AVG_SHIFT);
            end
        end
    end

    // ****************************************************************
    // Gain control
    // ****************************************************************
    logic [39:0] lvl_prod;
    logic [39:0] clip_prod;
    logic        clip_pred;
    logic        dir_dn;
    logic        dir_up;
    logic        fast;
    logic        boost;
    logic        tick;
    logic [23:0] period;
    logic [23:0] rate_cnt_ff;
    logic [15:0] nxt_gain;
    logic [15:0] step;

    assign lvl_prod  = peak_ff * gain_ff;
    assign clip_prod = abs_in * gain_ff;
    assign clip_pred = clip_prod[39:GAIN_FRAC] > {7'h00, FULL_SCALE};
    // Gate region below the gate level.
    assign gate_region = gate_ena && (peak_ff < GATE_LEVEL);

    // Attack on high level, decay on low level.
    assign dir_dn = ena && (gain_ff > eff_lo) && (gate_region || lvl_prod[39:GAIN_FRAC] > {7'h00, TARGET_HI});
    assign dir_up = ena && !gate_region && !dir_dn && (gain_ff < hi_lim) &&
                    (lvl_prod[39:GAIN_FRAC] < {7'h00, TARGET_LO});
    assign fast   = frel_ena && crest_hi;
    assign period = dir_dn ? atk_per : (fast ? fr_per : dcy_per);
    assign tick   = (dir_dn || dir_up) && (rate_cnt_ff >= period - 24'h000001);
    // Early clip detection forces a large step.
    assign boost  = guard && accept && clip_pred && (gain_ff > eff_lo);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rate_cnt_ff <= '0;
        end else if (!(dir_dn || dir_up) || tick) begin
            rate_cnt_ff <= '0;
        end else begin
            rate_cnt_ff <= rate_cnt_ff + 24'h000001;
        end
    end

    always_comb begin
        step     = gain_ff >> STEP_SHIFT;
        nxt_gain = gain_ff;
        if (boost) begin
            step     = gain_ff >> BOOST_SHIFT;
            nxt_gain = gain_ff - ((step == '0) ? 16'h0001 : step);
        end else if (tick && dir_dn) begin
            nxt_gain = gain_ff - ((step == '0) ? 16'h0001 : step);
        end else if (tick && dir_up) begin
            nxt_gain = gain_ff + step + 16'h0001;
        end
        if (nxt_gain < eff_lo) begin
            nxt_gain = eff_lo;
        end
        if (nxt_gain > hi_lim) begin
            nxt_gain = hi_lim;
        end
        if (!ena) begin
            nxt_gain = UNITY_GAIN;
        end
    end

    // Gain held as raw value over 512.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gain_ff <= UNITY_GAIN;
        end else begin
            gain_ff <= nxt_gain;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    gain_ceiling_a: assert property (gain_ff <= hi_lim || $changed(hi_lim)) else $error("gain above ceiling");
    gain_floor_a: assert property (ena && $past(ena) && $stable(eff_lo) && $stable(hi_lim) |-> gain_ff >= eff_lo)
        else $error("gain below floor");
    gain_unity_a: assert property (!ena ##1 !ena ##1 (!ena && $past(reg_addr) == GAIN_ADDR)
        |-> rdata_ff == UNITY_GAIN) else $error("disabled gain not unity");
    readback_live_a: assert property ($past(reg_addr) == GAIN_ADDR |-> rdata_ff == $past(gain_ff))
        else $error("readback not live gain");
    seed_level_a: assert property ($rose(ena) |=> peak_ff == $past(seed) && gain_ff == $past(nxt_gain))
        else $error("seed not applied");
    peak_hold_a: assert property (accept && !(ena && !ena_d_ff) |=> peak_ff >= $past(abs_in))
        else $error("peak lost sample");
    attack_down_a: assert property (tick && dir_dn && !boost && $stable(eff_lo) |=> gain_ff < $past(gain_ff))
        else $error("attack did not lower gain");
    fast_period_a: assert property (dir_up && fast |-> period == fr_per) else $error("fast rate not used");
    slow_period_a: assert property (dir_up && !fast |-> period == dcy_per) else $error("decay rate not used");
    atk_period_a: assert property (dir_dn |-> period == atk_per && atk_per >= 24'(ATK_BASE_CYC))
        else $error("attack rate not used");
    boost_step_a: assert property (boost ##1 $stable(eff_lo) |-> gain_ff < $past(gain_ff)) else $error("no boost");
    guard_delay_a: assert property (accept && guard |=> proc_data_ff == $past(out_sat))
        else $error("guard path wrong");

    attack_tick_c: cover property (tick && dir_dn);
    release_tick_c: cover property (tick && dir_up && fast);
    boost_seen_c: cover property (boost);
    fifo_full_c: cover property (proc_valid_ff && !fifo_ready);
endmodule

// ### verilog/dyn_pkg.sv
/*
 Constants for the gain dynamics block: register offsets, field positions,
 reset values, decode tables and timing counts.
 Assumes a 40 MHz system clock and 24-bit signed audio samples.
*/
package dyn_pkg;
    // Register offsets.
    localparam logic [7:0] FEAT_ADDR  = 8'h1d;
    localparam logic [7:0] LIMIT_ADDR = 8'h1e;
    localparam logic [7:0] TIME_ADDR  = 8'h1f;
    localparam logic [7:0] FREL_ADDR  = 8'h22;
    localparam logic [7:0] INIT_ADDR  = 8'h23;
    localparam logic [7:0] GAIN_ADDR  = 8'h24;
    // Field positions.
    localparam int ENA_BIT   = 7;
    localparam int GATE_BIT  = 8;
    localparam int FREL_BIT  = 2;
    localparam int GUARD_BIT = 1;
    localparam int MIN_LSB   = 2;
    localparam int MAX_LSB   = 0;
    localparam int GMIN_LSB  = 9;
    localparam int ATK_LSB   = 4;
    localparam int DCY_LSB   = 0;
    localparam int THR_LSB   = 2;
    localparam int RATE_LSB  = 0;
    localparam int INIT_LSB  = 0;
    // Reset values and implemented bits.
    localparam logic [15:0] FEAT_RST   = 16'h0006;
    localparam logic [15:0] LIMIT_RST  = 16'h0c05;
    localparam logic [15:0] TIME_RST   = 16'h0042;
    localparam logic [15:0] FREL_RST   = 16'h0000;
    localparam logic [15:0] INIT_RST   = 16'h0000;
    localparam logic [15:0] FEAT_MASK  = 16'h0186;
    localparam logic [15:0] LIMIT_MASK = 16'h1e1f;
    localparam logic [15:0] TIME_MASK  = 16'h00ff;
    localparam logic [15:0] FREL_MASK  = 16'h000f;
    localparam logic [15:0] INIT_MASK  = 16'h001f;
    // Highest and lowest usable codes; reserved codes clamp to these.
    localparam logic [2:0] MIN_CODE_MAX  = 3'h4;
    localparam logic [3:0] GMIN_CODE_MAX = 4'hc;
    localparam logic [3:0] ATK_CODE_MIN  = 4'h1;
    localparam logic [3:0] ATK_CODE_MAX  = 4'hb;
    localparam logic [3:0] DCY_CODE_MAX  = 4'h8;
    localparam logic [1:0] FREL_CODE_MAX = 2'h2;
    // Gains as Q7.9 multipliers.
    localparam logic [15:0] UNITY_GAIN = 16'h0200;
    localparam logic [15:0] MIN_TBL [5] = '{16'h0200, 16'h0080, 16'h0040, 16'h0020, 16'h0008};
    localparam logic [15:0] MAX_TBL [4] = '{16'h07f7, 16'h0fe2, 16'h1fb3, 16'h7e37};
    localparam logic [15:0] GMIN_TBL [13] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080,
        16'h00ff, 16'h0200, 16'h03fe, 16'h07f7, 16'h0fe2, 16'h1fb3, 16'h3f3f, 16'h7e37};
    // Expected level seeds for one 30 dB span, in 3.75 dB steps.
    localparam logic [23:0] SEED_TBL [8] = '{24'h7fffff, 24'h53126e, 24'h360418, 24'h23126e,
        24'h16c8b4, 24'h0eb852, 24'h09999a, 24'h063bcd};
    localparam int SEED_OCT_SHIFT = 5;
    // Signal levels.
    localparam logic [23:0] FULL_SCALE = 24'h7fffff;
    localparam logic [23:0] TARGET_HI  = 24'h400000;
    localparam logic [23:0] TARGET_LO  = 24'h200000;
    localparam logic [23:0] GATE_LEVEL = 24'h0020c5;
    // Arithmetic shifts.
    localparam int GAIN_FRAC   = 9;
    localparam int STEP_SHIFT  = 8;
    localparam int BOOST_SHIFT = 4;
    localparam int PEAK_SHIFT  = 10;
    localparam int AVG_SHIFT   = 6;
    localparam int THR_SHIFT0  = 2;
    localparam int LOOKAHEAD   = 4;
    // Timing: one gain step of 1/256 is taken per tick; 177 steps make 6 dB.
    localparam int CLK_MHZ       = 40;
    localparam int STEPS_PER_6DB = 177;
    localparam int ATK_BASE_NS   = 181000;
    localparam int DCY_BASE_US   = 186000;
    localparam int FR_NS [3]     = '{725000, 1450000, 5800000};
    localparam int ATK_BASE_CYC_DEF = ATK_BASE_NS * CLK_MHZ / (1000 * STEPS_PER_6DB);
    localparam int DCY_BASE_CYC_DEF = DCY_BASE_US * CLK_MHZ / STEPS_PER_6DB;
    localparam logic [23:0] FR_CYC [3] = '{24'(FR_NS[0] * CLK_MHZ / (1000 * STEPS_PER_6DB)),
        24'(FR_NS[1] * CLK_MHZ / (1000 * STEPS_PER_6DB)), 24'(FR_NS[2] * CLK_MHZ / (1000 * STEPS_PER_6DB))};
endpackage

// ### verilog/sample_fifo.sv
/*
 Small synchronous FIFO for processed samples.
 Assumes one clock; both sides use valid and ready.
*/
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### testbench/dsp_path_model.sv
/*
 Sink end of the audio path: takes processed samples in order and can stall.
 Assumes one clock; the sink's ready changes at the falling edge.
*/
`timescale 1ns/1ps
module dsp_path_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [23:0] out_data,
    output logic             out_ready
);
    logic [23:0] seen [$];
    initial out_ready = 1'b0;
    always @(negedge clock) out_ready <= !stall;
    always @(posedge clock) if (!rst && out_valid === 1'b1 && out_ready) seen.push_back(out_data);
endmodule

// ### testbench/tb_top.sv
/*
 Self-checking bench for the gain dynamics block.
 Assumes the hand-over timing; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module tb_top;
    import dyn_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        in_valid = 1'b0;
    logic        in_ready;
    logic [23:0] in_data = 24'h000000;
    logic        out_valid;
    logic        out_ready;
    logic [23:0] out_data;
    logic        stall = 1'b0;
    int          err_total = 0;
    int          compares = 0;
    always #12.5 clock = !clock;
    applied_gain_readback_dynamics #(.ATK_BASE_CYC(2), .DCY_BASE_CYC(20)) dut_u (.clock(clock), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data));
    dsp_path_model model_u (.clock(clock), .rst(rst), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        @(negedge clock);
        chk($sformatf("register %h", a), 24'(exp), 24'(reg_rdata));
    endtask
    task automatic put(input logic [23:0] d);
        in_valid = 1'b1;
        in_data = d;
        for (int i = 0; i < 200 && in_ready !== 1'b1; i++) @(negedge clock);
        @(negedge clock);
    endtask
    task automatic take(input logic [23:0] exp);
        for (int i = 0; i < 50 && model_u.seen.size() == 0; i++) @(negedge clock);
        chk("output sample", exp, model_u.seen.size() > 0 ? model_u.seen.pop_front() : 24'hxxxxxx);
    endtask
    // Streams samples of alternating sign and checks the live gain stays inside lo..hi.
    task automatic run(input logic [23:0] d, input int n, input logic [15:0] lo, input logic [15:0] hi);
        reg_addr = GAIN_ADDR;
        for (int i = 0; i < n; i++) begin
            put(i[0] ? -d : d);
            compares++;
            if ((reg_rdata >= lo && reg_rdata <= hi) !== 1'b1) begin
                err_total++;
                $display("unexpected gain expected %h to %h seen %h", lo, hi, reg_rdata);
            end
        end
        in_valid = 1'b0;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_guard;
        for (int i = 1; i <= 6; i++) put(24'(i * 257));
        in_valid = 1'b0;
        for (int i = 1; i <= 6; i++) take(i > 4 ? 24'((i - 4) * 257) : 24'h000000);
        $display("test guard_delay done");
    endtask
    task automatic t_regs;
        logic [7:0]  a [6] = '{8'h1d, 8'h1e, 8'h1f, 8'h22, 8'h23, 8'h20};
        logic [15:0] r [6] = '{16'h0006, 16'h0c05, 16'h0042, 16'h0000, 16'h0000, 16'h0000};
        logic [15:0] m [6] = '{16'h0186, 16'h1e1f, 16'h00ff, 16'h000f, 16'h001f, 16'h0000};
        rd(GAIN_ADDR, 16'h0200);
        wr(GAIN_ADDR, 16'h1234);
        rd(GAIN_ADDR, 16'h0200);
        for (int i = 0; i < 6; i++) rd(a[i], r[i]);
        for (int i = 0; i < 6; i++) begin
            wr(a[i], 16'hffff);
            rd(a[i], m[i]);
            wr(a[i], r[i]);
        end
        $display("test registers done");
    endtask
    task automatic t_fifo;
        int n;
        n = 0;
        wr(FEAT_ADDR, 16'h0000);
        stall = 1'b1;
        @(negedge clock);
        while (n < 12 && in_ready === 1'b1) begin
            put(24'h800001 + 24'(n));
            n++;
        end
        in_valid = 1'b0;
        chk("accepted count", 24'd9, 24'(n));
        stall = 1'b0;
        for (int i = 0; i < 9; i++) take(24'h800001 + 24'(i));
        $display("test fifo_fill done");
    endtask
    task automatic t_limits;
        wr(TIME_ADDR, 16'h0010);
        wr(LIMIT_ADDR, 16'h0c01);
        wr(FEAT_ADDR, 16'h0080);
        run(24'h7fffff, 800, 16'h0200, 16'h0200);
        wr(LIMIT_ADDR, 16'h0c05);
        run(24'h7fffff, 1000, 16'h0080, 16'h0200);
        run(24'h7fffff, 20, 16'h0080, 16'h0100);
        wr(LIMIT_ADDR, 16'h0c04);
        run(24'h000000, 25000, 16'h0080, 16'h07f7);
        rd(GAIN_ADDR, 16'h07f7);
        $display("test gain_limits done");
    endtask
    // Clip guard cuts a high gain within a few samples; fast release then lifts it at its own rate.
    task automatic t_dynamics;
        logic [15:0] g0;
        wr(FEAT_ADDR, 16'h0082);
        run(24'h7fffff, 30, 16'h0080, 16'h07f7);
        run(24'h7fffff, 4, 16'h0080, 16'h0200);
        wr(TIME_ADDR, 16'h0018);
        wr(FEAT_ADDR, 16'h0084);
        run(24'h000000, 1000, 16'h0080, 16'h0200);
        g0 = reg_rdata;
        run(24'h000000, 1300, g0, 16'h0200);
        compares++;
        if (reg_rdata < g0 + 16'h0008) begin
            err_total++;
            $display("unexpected released gain expected %h or more seen %h", g0 + 16'h0008, reg_rdata);
        end
        $display("test clip_guard_release done");
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1500000;
        err_total++;
        close_out;
    end
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        t_guard;
        t_regs;
        t_fifo;
        t_limits;
        t_dynamics;
        close_out;
    end
endmodule
